//--- sac_adc_ctrl.sv
// Conversion sequencing, busy status and result bus drive of a sampling converter
// Assumes cs_n and rd_conv arrive from pins; the analog core gives a code to latch
//
// Summary of operation
// - New result valid on outputs within 8 us of start edge.
// - Previous result stays valid typically 7.4 us after start.
// - Busy rises at least 50 ns after new result is valid.
// - Busy rises typically 220 ns after internal end of conversion.
// - Chip select ORed with select input; falling edge starts, chip select low with select input high enables output.
// - Busy low throughout conversion; data valid at its rising edge.
// - Result bus floats when chip select high or select input low.
`include "sac_defines.svh"
module sac_adc_ctrl
    import sac_pkg::*;
#(
    parameter int WIDTH = `SAC_WIDTH
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clk_en,
    input  wire logic             cs_n,
    input  wire logic             rd_conv,
    input  wire logic [WIDTH-1:0] sample_code,
    output logic                  busy,
    output logic                  conv_start,
    output logic [WIDTH-1:0]      result_bus_out,
    output logic [WIDTH-1:0]      result_bus_oe
);
    // ------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------
    localparam logic [7:0] PREV_CYC = 8'(`SAC_PREV_CYC);
    localparam logic [7:0] EOC_CYC  = 8'(`SAC_EOC_CYC);
    localparam logic [7:0] LEAD_CYC = 8'(`SAC_LEAD_CYC);
    localparam int         VALID_CYC = `SAC_VALID_CYC;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic cs_s;
    logic rc_s;

    // Both synchronised levels reset high, so no false edge follows release
    sac_sync u_cs (
        .clk    (clk),
        .rst_n  (rst_n),
        .clk_en (clk_en),
        .pin    (cs_n),
        .level  (cs_s)
    );
    sac_sync u_rc (
        .clk    (clk),
        .rst_n  (rst_n),
        .clk_en (clk_en),
        .pin    (rd_conv),
        .level  (rc_s)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        sac_state_t       st;
        logic [7:0]       cnt;
        logic             busy;
        logic             start;
        logic             gate_q;
        logic             drive;
        logic [WIDTH-1:0] result;
        logic [WIDTH-1:0] hold;
    } sac_regs_t;

    sac_regs_t r;
    sac_regs_t next_r;
    logic      gate;

    // OR of chip select and select input, active low
    function automatic logic sac_or(input logic c, input logic s);
        return c | s;
    endfunction

    // Sequencer and output drive
    always_comb begin
        next_r       = r;
        next_r.start = 1'b0;
        gate         = sac_or(cs_s, rc_s);
        next_r.gate_q = gate;
        next_r.drive = !cs_s && rc_s;
        case (r.st)
            SAC_IDLE: begin
                // Falling edge of combined input starts a conversion
                if (r.gate_q && !gate) begin
                    next_r.st    = SAC_CONV;
                    next_r.cnt   = 8'h00;
                    next_r.busy  = 1'b0;
                    next_r.start = 1'b1;
                    next_r.hold  = sample_code;
                end
            end
            SAC_CONV: begin
                // Old result kept until the typical handover time
                next_r.cnt = r.cnt + 8'h01;
                if (r.cnt == PREV_CYC - 8'h01) begin
                    next_r.st     = SAC_EOC;
                    next_r.cnt    = 8'h00;
                    next_r.result = r.hold;
                end
            end
            SAC_EOC: begin
                next_r.cnt = r.cnt + 8'h01;
                if (r.cnt == EOC_CYC - 8'h01) begin
                    next_r.st  = SAC_IDLE;
                    next_r.busy = 1'b1;
                end
            end
            default: begin
                next_r.st = SAC_IDLE;
            end
        endcase
        // Start edges during conversion fall through untouched
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{st: SAC_IDLE, cnt: 8'h00, busy: 1'b1, start: 1'b0, gate_q: 1'b1,
                   drive: 1'b0, result: '0, hold: '0};
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    assign busy           = r.busy;
    assign conv_start     = r.start;
    assign result_bus_out = r.result;
    assign result_bus_oe  = {WIDTH{r.drive}};

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    int unsigned since_start;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            since_start <= 0;
        end else if (r.start) begin
            since_start <= 1;
        end else if (clk_en && since_start != 0 && since_start < 1000) begin
            since_start <= since_start + 1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n || !clk_en);

    // Busy returns within the longest conversion time
    result_in_time_a: assert property (r.busy && !$past(r.busy) |-> since_start <= VALID_CYC)
        else $error("result later than allowed");
    // Old result held through the first cycles of a conversion
    prev_kept_a: assert property (r.start |=> $stable(r.result)[*8])
        else $error("previous result lost early");
    // Result settled before busy rises
    lead_busy_a: assert property ($rose(r.busy) |-> $past(r.st) == SAC_EOC && $stable(r.result))
        else $error("busy rose with result changing");
    // Busy follows the internal end of conversion
    eoc_delay_a: assert property ($changed(r.result) && r.st == SAC_EOC |-> ##2 $rose(r.busy))
        else $error("busy not raised after end of conversion");
    // Busy drops with the start pulse
    busy_low_a: assert property (r.start |-> !r.busy)
        else $error("busy high while converting");
    // Bus released when deselected or select input low
    float_a: assert property ((cs_s || !rc_s) |=> !r.drive)
        else $error("result bus driven when disabled");
    // No start pulse while a conversion runs
    no_restart_a: assert property (r.st != SAC_IDLE |=> !r.start)
        else $error("conversion restarted");
    // Falling combined select in idle always starts
    start_edge_a: assert property (r.st == SAC_IDLE && r.gate_q && !sac_or(cs_s, rc_s) |=> r.start)
        else $error("start edge missed");

    // Result only moves on the hand-over into the end phase
    result_move_a: assert property ($changed(r.result) |-> r.st == SAC_EOC && $past(r.st) == SAC_CONV)
        else $error("result changed outside hand-over");

    // Old result still stands one cycle before the hand-over
    prev_long_a: assert property (r.start |-> ##73 $stable(r.result))
        else $error("previous result replaced too soon");

    // Busy low in every phase of a conversion
    busy_during_a: assert property (r.st != SAC_IDLE |-> !r.busy)
        else $error("busy high during conversion");

    // Busy high whenever the sequencer rests
    busy_idle_a: assert property (r.st == SAC_IDLE |-> r.busy)
        else $error("busy low while idle");

    // A conversion never outlives the longest allowed time
    conv_bound_a: assert property (since_start > VALID_CYC && !r.start |-> r.st == SAC_IDLE)
        else $error("conversion overran its time");

    // Start pulse lasts a single cycle
    start_pulse_a: assert property (r.start |=> !r.start)
        else $error("start pulse too long");

    // Hand-over counter stays inside its phase
    cnt_range_a: assert property (r.st == SAC_CONV |-> r.cnt < PREV_CYC)
        else $error("hand-over count overran");

    // End-of-conversion counter stays inside its phase
    eoc_range_a: assert property (r.st == SAC_EOC |-> r.cnt < EOC_CYC)
        else $error("busy delay count overran");

    // Bus driven once selected for reading
    drive_on_a: assert property (!cs_s && rc_s |=> r.drive)
        else $error("result bus not driven when read");

    // ------------------------------------------------------------
    // Coverage of the main scenarios
    // ------------------------------------------------------------
    conv_done_c:    cover property ($rose(r.busy));
    read_c:         cover property (r.drive && r.busy);
    ignored_c:      cover property (r.st == SAC_CONV && r.gate_q && !sac_or(cs_s, rc_s));
    back_to_back_c: cover property ($rose(r.busy) ##[1:40] r.start);
endmodule // sac_adc_ctrl

//--- sac_defines.svh
// Timing constants for the conversion-control block
// Assumes a 10 MHz clock; all counts derived from times in ns
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH
`define SAC_CLK_PERIOD_NS   100
`define SAC_RESULT_VALID_NS 8000
`define SAC_PREV_VALID_NS   7400
`define SAC_BUSY_AFTER_NS   50
`define SAC_BUSY_EOC_NS     220
// Longest time rounds down, least time rounds up, typical rounds down
`define SAC_PREV_CYC   (`SAC_PREV_VALID_NS / `SAC_CLK_PERIOD_NS)
`define SAC_EOC_CYC    (`SAC_BUSY_EOC_NS / `SAC_CLK_PERIOD_NS)
`define SAC_LEAD_CYC   ((`SAC_BUSY_AFTER_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)
`define SAC_VALID_CYC  (`SAC_RESULT_VALID_NS / `SAC_CLK_PERIOD_NS)
`define SAC_WIDTH      16
`endif

//--- sac_pkg.sv
// Types for the conversion-control block
// Assumes sac_defines.svh is available on the include path
package sac_pkg;
    typedef enum logic [1:0] {
        SAC_IDLE,
        SAC_CONV,
        SAC_EOC,
        SAC_LEAD
    } sac_state_t;
endpackage

//--- sac_sync.sv
// Three-stage synchroniser with agreement filter
// Assumes an asynchronous pin input and a single clock domain
module sac_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    input  wire logic pin,
    output logic      level
);
    logic [2:0] stage;

    // Level changes only once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage <= 3'b111;
            level <= 1'b1;
        end else if (clk_en) begin
            stage <= {stage[1:0], pin};
            if (stage[1] == stage[2]) begin
                level <= stage[2];
            end
        end
    end
endmodule // sac_sync

//--- sac_host.sv
// Host model: starts conversions through chip select or the select pin
// Assumes the bench raises go for one cycle per conversion
module sac_host (
    input  wire logic clk,
    input  wire logic go,
    input  wire logic via_cs,
    output logic      cs_n,
    output logic      rd_conv
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cs_n = 1'b0;
        rd_conv = 1'b1;
    end
    // Park the pins, make one start edge, then return to read
    always @(posedge clk) begin
        if (go) begin
            #5;
            cs_n = via_cs;
            rd_conv = !via_cs;
            repeat (5) @(posedge clk);
            #5;
            cs_n = 1'b0;
            rd_conv = 1'b0; // Falling edge of the ORed pins
            repeat (20) @(posedge clk);
            #5;
            rd_conv = 1'b1; // High within 3 us and before busy rises
        end
    end
endmodule // sac_host

//--- testbench.sv
// Self-checking bench for the conversion-control block
// Assumes a 10 MHz clock and the host model driving the select pins
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_n, clk_en, go, via_cs, busy, conv_start, cs_n, rd_conv;
    logic [15:0] sample_code, code, old, result_bus_out, result_bus_oe;
    int          n_fail, num_checks, seed, n, m;
    sac_host hst (.clk(clk), .go(go), .via_cs(via_cs), .cs_n(cs_n), .rd_conv(rd_conv));
    sac_adc_ctrl uut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .cs_n(cs_n), .rd_conv(rd_conv),
        .sample_code(sample_code), .busy(busy), .conv_start(conv_start),
        .result_bus_out(result_bus_out), .result_bus_oe(result_bus_oe));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step;
        @(posedge clk);
        #5;
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // One conversion; a second start edge mid-way when twice is set
    task automatic convert(input logic cs_start, input logic twice);
        old = result_bus_out;
        code = 16'($random(seed));
        if (code === old) code = ~old;
        sample_code = code;
        via_cs = cs_start;
        go = 1'b1;
        step;
        go = 1'b0;
        n = 0;
        while (conv_start !== 1'b1 && n < 20) begin
            step;
            n++;
        end
        check("start", {15'h0, conv_start}, 16'h0001);
        sample_code = ~code;
        n = 0;
        while (result_bus_out === old && n < 90) begin
            go = twice && n == 40;
            step;
            n++;
            check("busy low", {15'h0, busy | conv_start}, 16'h0000);
            if (n == 10) check("float", result_bus_oe, 16'h0000);
        end
        check("prev time", 16'(n), 16'd74);
        check("result", result_bus_out, code);
        m = 0;
        while (busy !== 1'b1 && m < 10) begin
            step;
            m++;
        end
        check("busy delay", 16'(m), 16'd2);
        check("total", {15'h0, n + m <= 80}, 16'h0001);
    endtask
    initial begin
        #500000;
        n_fail++;
        end_sim;
    end
    initial begin
        seed = 42003;
        rst_n = 1'b0;
        clk_en = 1'b1;
        go = 1'b0;
        via_cs = 1'b0;
        sample_code = 16'h0000;
        n_fail = 0;
        num_checks = 0;
        repeat (2) @(posedge clk);
        check("reset busy", {15'h0, busy}, 16'h0001);
        #5 rst_n = 1'b1;
        repeat (6) step;
        for (int i = 0; i < 6; i++) begin
            convert(i[0], i == 3);
            repeat (6) step;
            check("read enable", result_bus_oe, 16'hFFFF);
            $display("test %0d done", i);
        end
        // Clock enable low freezes every output
        old = result_bus_out;
        clk_en = 1'b0;
        repeat (8) step;
        check("freeze result", result_bus_out, old);
        check("freeze busy", {15'h0, busy}, 16'h0001);
        check("freeze enable", result_bus_oe, 16'hFFFF);
        clk_en = 1'b1;
        $display("test freeze done");
        end_sim;
    end
endmodule // testbench
